// ===== include/lais_defs.svh
// Constants for the per-channel line alarm interrupt status block
`ifndef LAIS_DEFS_SVH
`define LAIS_DEFS_SVH
`define LAIS_NCH        16
`define LAIS_SYNC_W     160
`define LAIS_ADDR_W     12
`define LAIS_CH_MSB     11
`define LAIS_CH_LSB     8
`define LAIS_OFF_MSB    7
`define LAIS_OFF_LSB    2
`define LAIS_IDX_MASK0  6'h19
`define LAIS_IDX_MASK1  6'h1A
`define LAIS_IDX_EDGE   6'h1B
`define LAIS_IDX_STATE0 6'h1E
`define LAIS_IDX_STATE1 6'h1F
`define LAIS_IDX_FLAGS0 6'h20
`define LAIS_IDX_FLAGS1 6'h21
`define LAIS_FLAG_RST   8'h00
`define LAIS_MASK_RST   8'hFF
`define LAIS_EDGE_RST   8'h00
`define LAIS_USED0      8'hFF
`define LAIS_USED1      8'hE3
`define LAIS_USED_EDGE  8'h7F
`define LAIS_LVL0       8'h1F
`define LAIS_ES_IB      0
`define LAIS_ES_LOS     1
`define LAIS_ES_TL      2
`define LAIS_ES_CK      3
`define LAIS_ES_OC      4
`define LAIS_ES_PA      5
`define LAIS_ES_AIS     6
`endif

// ===== include/lais_pkg.sv
// Types shared by the line alarm interrupt status block
`include "lais_defs.svh"
package lais_pkg;
  typedef logic [3:0] lais_chan_t;
  typedef logic [7:0] lais_byte_t;
  typedef struct packed {
    lais_byte_t flags0;
    lais_byte_t flags1;
    lais_byte_t prev0;
    lais_byte_t prev1;
  } lais_chan_s;
  typedef struct packed {
    logic [`LAIS_SYNC_W-1:0] meta;
    logic [`LAIS_SYNC_W-1:0] stable;
  } lais_sync_s;
  typedef struct packed {
    logic [`LAIS_NCH-1:0][7:0] edge_sel;
    logic [`LAIS_NCH-1:0][7:0] mask0;
    logic [`LAIS_NCH-1:0][7:0] mask1;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic                      irq;
  } lais_top_s;
endpackage

// ===== verilog/lais_sync.sv
// Two-stage synchroniser for the detector status levels
`timescale 1ns/1ps
`include "lais_defs.svh"
module lais_sync (
  input  wire logic                    pclk,    // Clock
  input  wire logic                    presetn, // Async reset, low
  input  wire logic [`LAIS_SYNC_W-1:0] d,       // Levels from other domains
  output logic      [`LAIS_SYNC_W-1:0] q        // Synchronised levels
);
  lais_pkg::lais_sync_s r;
  lais_pkg::lais_sync_s n;

  // First stage is read only by the second stage
  always_comb begin
    n        = r;
    n.meta   = d;
    n.stable = r.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.stable;
endmodule

// ===== verilog/lais_chan.sv
// Sticky interrupt flags of one channel with edge selection
`timescale 1ns/1ps
`include "lais_defs.svh"
module lais_chan (
  input  wire logic       pclk,        // Clock
  input  wire logic       presetn,     // Async reset, low
  input  wire logic [7:0] edge_sel,    // Edge-select register
  input  wire logic [7:0] line_state,  // Line status levels, flag0 layout
  input  wire logic [7:0] alarm_state, // Alarm status levels, flag1 layout
  input  wire logic [2:0] evt,         // Amplitude, tx slip, rx slip pulses
  input  wire logic [7:0] clr0,        // Write-one-to-clear, first flags
  input  wire logic [7:0] clr1,        // Write-one-to-clear, second flags
  output logic      [7:0] flags0,      // First flag register
  output logic      [7:0] flags1       // Second flag register
);
  lais_pkg::lais_chan_s r;
  lais_pkg::lais_chan_s n;
  logic [7:0] es0;
  logic [7:0] es1;
  logic [7:0] set0;
  logic [7:0] set1;

  assign es0 = {3'h0, edge_sel[`LAIS_ES_OC], edge_sel[`LAIS_ES_CK], edge_sel[`LAIS_ES_TL],
                edge_sel[`LAIS_ES_LOS], edge_sel[`LAIS_ES_LOS]}; // RULE_09
  assign es1 = {edge_sel[`LAIS_ES_AIS], edge_sel[`LAIS_ES_AIS], edge_sel[`LAIS_ES_PA], 3'h0,
                edge_sel[`LAIS_ES_IB], edge_sel[`LAIS_ES_IB]}; // RULE_10

  // Select clear: rising edge only; select set: any transition
  assign set0 = {evt, 5'h00} // RULE_01 RULE_02 RULE_03
              | (`LAIS_LVL0 & ((es0 & (line_state ^ r.prev0))
                 | (~es0 & line_state & ~r.prev0))); // RULE_06 RULE_07 RULE_08
  assign set1 = `LAIS_USED1 & ((es1 & (alarm_state ^ r.prev1))
                | (~es1 & alarm_state & ~r.prev1)); // RULE_10 RULE_11 RULE_12

  // A set arriving with its clear wins, so no event is lost
  always_comb begin
    n        = r;
    n.flags0 = (r.flags0 & ~clr0) | set0; // RULE_15
    n.flags1 = (r.flags1 & ~clr1) | set1; // RULE_04
    n.prev0  = line_state;                // RULE_06
    n.prev1  = alarm_state;               // RULE_12
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign flags0 = r.flags0;
  assign flags1 = r.flags1;

  property p_rise(logic st, logic fl);
    @(posedge pclk) disable iff (!presetn) st && !$past(st) |=> fl;
  endproperty
  property p_fall(logic st, logic es, logic fl);
    @(posedge pclk) disable iff (!presetn) es && !st && $past(st) && $past(es) |=> fl;
  endproperty

  a_amp_evt_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    evt[2] |=> flags0[7]) else $error("amplitude flag not set");
  a_txj_evt_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    evt[1] |=> flags0[6]) else $error("tx slip flag not set");
  a_rxj_evt_sets: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    evt[0] |=> flags0[5]) else $error("rx slip flag not set");
  a_flag_clears: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    clr0[6] && !evt[1] |=> !flags0[6]) else $error("flag not cleared");
  a_oc_rise: assert property (p_rise(line_state[4], flags0[4])) // RULE_06
    else $error("overcurrent rise lost");
  a_oc_fall: assert property (p_fall(line_state[4], edge_sel[4], flags0[4])) // RULE_06
    else $error("overcurrent fall lost");
  a_ck_fall: assert property (p_fall(line_state[3], edge_sel[3], flags0[3])) // RULE_07
    else $error("clock missing fall lost");
  a_tl_fall: assert property (p_fall(line_state[2], edge_sel[2], flags0[2])) // RULE_08
    else $error("tx loss fall lost");
  a_los_fall: assert property (p_fall(line_state[0], edge_sel[1], flags0[0])) // RULE_09
    else $error("line loss fall lost");
  a_ais_fall: assert property (p_fall(alarm_state[7], edge_sel[6], flags1[7])) // RULE_10
    else $error("alarm fall lost");
  a_pa_fall: assert property (p_fall(alarm_state[5], edge_sel[5], flags1[5])) // RULE_11
    else $error("pattern fall lost");
  a_ib_fall: assert property (p_fall(alarm_state[1], edge_sel[0], flags1[1])) // RULE_12
    else $error("inband fall lost");
  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
    flags0[4] && !clr0[4] |=> flags0[4]) else $error("flag dropped alone");
endmodule

// ===== verilog/lais_irq_status.sv
// Per-channel latched line alarm interrupt status with APB access
// Functional notes
// RULE_01: Amplitude overflow sets flag bit 7 of the first register and raises interrupt.
// RULE_02: Transmit jitter FIFO slip sets bit 6 of the first register.
// RULE_03: Receive jitter FIFO slip sets bit 5 of the first register.
// RULE_04: Flags reset to zero; writing one to a bit clears it.
// RULE_05: Any set flag whose mask bit is zero is reported on the interrupt output.
// RULE_06: Overcurrent flag bit 4: rising edge, or any edge when selected.
// RULE_07: Clock missing flag bit 3: rising edge, or any edge when selected.
// RULE_08: Transmit loss flag bit 2: rising edge, or any edge when selected.
// RULE_09: System and line loss flags share edge-select bit 1.
// RULE_10: Both alarm indication flags, bits 7 and 6, share edge-select bit 6.
// RULE_11: Pattern sync flag bit 5 uses edge-select bit 5.
// RULE_12: Loop up and loop down code flags share edge-select bit 0.
// RULE_13: Sixteen channels, register copies spaced 40H apart from 020H and 021H.
// RULE_14: Mask bits reset to one; a one blocks the source from interrupt.
// RULE_15: A set flag stays set until software writes one to it.
`timescale 1ns/1ps
`include "lais_defs.svh"
module lais_irq_status (
  input  wire logic                    pclk,                     // APB clock, 40 MHz
  input  wire logic                    presetn,                  // Async reset, low
  input  wire logic                    psel,                     // APB select
  input  wire logic                    penable,                  // APB enable
  input  wire logic                    pwrite,                   // APB direction
  input  wire logic [`LAIS_ADDR_W-1:0] paddr,                    // APB byte address
  input  wire logic [31:0]             pwdata,                   // APB write data
  output logic      [31:0]             prdata,                   // APB read data
  output logic                         pready,                   // APB ready
  output logic                         pslverr,                  // APB error
  output logic                         irq_out,                  // Level interrupt
  input  wire logic [`LAIS_NCH-1:0]    amplitude_overflow_evt,   // Pulses, same clock
  input  wire logic [`LAIS_NCH-1:0]    tx_jitter_fifo_slip_evt,  // Pulses, same clock
  input  wire logic [`LAIS_NCH-1:0]    rx_jitter_fifo_slip_evt,  // Pulses, same clock
  input  wire logic [`LAIS_NCH-1:0]    overcurrent_state,        // Async level
  input  wire logic [`LAIS_NCH-1:0]    clock_missing_state,      // Async level
  input  wire logic [`LAIS_NCH-1:0]    tx_signal_loss_state,     // Async level
  input  wire logic [`LAIS_NCH-1:0]    system_signal_loss_state, // Async level
  input  wire logic [`LAIS_NCH-1:0]    line_signal_loss_state,   // Async level
  input  wire logic [`LAIS_NCH-1:0]    system_alarm_ind_state,   // Async level
  input  wire logic [`LAIS_NCH-1:0]    line_alarm_ind_state,     // Async level
  input  wire logic [`LAIS_NCH-1:0]    pattern_sync_state,       // Async level
  input  wire logic [`LAIS_NCH-1:0]    loop_up_code_state,       // Async level
  input  wire logic [`LAIS_NCH-1:0]    loop_down_code_state      // Async level
);
  lais_pkg::lais_top_s r;
  lais_pkg::lais_top_s n;

  logic [`LAIS_SYNC_W-1:0]   sync_q;
  logic [`LAIS_NCH-1:0]      oc_s;
  logic [`LAIS_NCH-1:0]      ck_s;
  logic [`LAIS_NCH-1:0]      tl_s;
  logic [`LAIS_NCH-1:0]      sl_s;
  logic [`LAIS_NCH-1:0]      ll_s;
  logic [`LAIS_NCH-1:0]      sa_s;
  logic [`LAIS_NCH-1:0]      la_s;
  logic [`LAIS_NCH-1:0]      pt_s;
  logic [`LAIS_NCH-1:0]      iu_s;
  logic [`LAIS_NCH-1:0]      id_s;
  logic [`LAIS_NCH-1:0][7:0] st0_w;
  logic [`LAIS_NCH-1:0][7:0] st1_w;
  logic [`LAIS_NCH-1:0][7:0] flags0_w;
  logic [`LAIS_NCH-1:0][7:0] flags1_w;
  logic [`LAIS_NCH-1:0][7:0] clr0_w;
  logic [`LAIS_NCH-1:0][7:0] clr1_w;
  logic [`LAIS_NCH-1:0]      pend;
  lais_pkg::lais_chan_t      ch_sel;
  logic [5:0]                off;
  logic                      setup;
  logic                      wr_take;
  logic                      hit;
  lais_pkg::lais_byte_t      rd_byte;

  // Detector levels come from other clock domains and analog monitors
  lais_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({overcurrent_state, clock_missing_state, tx_signal_loss_state,
               system_signal_loss_state, line_signal_loss_state,
               system_alarm_ind_state, line_alarm_ind_state, pattern_sync_state,
               loop_up_code_state, loop_down_code_state}),
    .q       (sync_q)
  );

  assign {oc_s, ck_s, tl_s, sl_s, ll_s, sa_s, la_s, pt_s, iu_s, id_s} = sync_q;

  // Address decode: channel in the upper bits, register index below
  assign ch_sel  = paddr[`LAIS_CH_MSB:`LAIS_CH_LSB]; // RULE_13
  assign off     = paddr[`LAIS_OFF_MSB:`LAIS_OFF_LSB]; // RULE_13
  assign setup   = psel & ~penable;
  // Writes land only on the edge that completes the access
  assign wr_take = psel & penable & pwrite & r.pready;

  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    case (off)
      `LAIS_IDX_FLAGS0: rd_byte = flags0_w[ch_sel]; // RULE_13
      `LAIS_IDX_FLAGS1: rd_byte = flags1_w[ch_sel]; // RULE_13
      `LAIS_IDX_MASK0:  rd_byte = r.mask0[ch_sel];
      `LAIS_IDX_MASK1:  rd_byte = r.mask1[ch_sel];
      `LAIS_IDX_EDGE:   rd_byte = r.edge_sel[ch_sel];
      `LAIS_IDX_STATE0: rd_byte = st0_w[ch_sel];
      `LAIS_IDX_STATE1: rd_byte = st1_w[ch_sel];
      default:          hit     = 1'b0;
    endcase
  end

  generate
    for (genvar c = 0; c < `LAIS_NCH; c++) begin : g_ch
      assign st0_w[c] = {3'h0, oc_s[c], ck_s[c], tl_s[c], sl_s[c], ll_s[c]};
      assign st1_w[c] = {sa_s[c], la_s[c], pt_s[c], 3'h0, iu_s[c], id_s[c]};
      assign clr0_w[c] = (wr_take && ch_sel == lais_pkg::lais_chan_t'(c)
                          && off == `LAIS_IDX_FLAGS0) ? pwdata[7:0] : 8'h00; // RULE_04
      assign clr1_w[c] = (wr_take && ch_sel == lais_pkg::lais_chan_t'(c)
                          && off == `LAIS_IDX_FLAGS1) ? pwdata[7:0] : 8'h00; // RULE_04
      // A mask bit of one keeps its flag off the interrupt line
      assign pend[c] = |((flags0_w[c] & ~r.mask0[c])
                         | (flags1_w[c] & ~r.mask1[c])); // RULE_14

      lais_chan u_chan (
        .pclk        (pclk),
        .presetn     (presetn),
        .edge_sel    (r.edge_sel[c]),
        .line_state  (st0_w[c]),
        .alarm_state (st1_w[c]),
        .evt         ({amplitude_overflow_evt[c], tx_jitter_fifo_slip_evt[c],
                       rx_jitter_fifo_slip_evt[c]}),
        .clr0        (clr0_w[c]),
        .clr1        (clr1_w[c]),
        .flags0      (flags0_w[c]),
        .flags1      (flags1_w[c])
      );
    end
  endgenerate

  // Zero wait state slave: ready and read data are registered in setup
  always_comb begin
    n         = r;
    n.pready  = setup;
    n.pslverr = setup & ~hit;
    if (setup) begin
      n.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
    if (wr_take) begin
      case (off)
        `LAIS_IDX_MASK0: n.mask0[ch_sel]    = pwdata[7:0] & `LAIS_USED0;
        `LAIS_IDX_MASK1: n.mask1[ch_sel]    = pwdata[7:0] & `LAIS_USED1;
        `LAIS_IDX_EDGE:  n.edge_sel[ch_sel] = pwdata[7:0] & `LAIS_USED_EDGE;
        default:         n.irq              = r.irq;
      endcase
    end
    n.irq = |pend; // RULE_05
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r          <= '0;
      r.mask0    <= {`LAIS_NCH{`LAIS_MASK_RST}}; // RULE_14
      r.mask1    <= {`LAIS_NCH{`LAIS_MASK_RST & `LAIS_USED1}}; // RULE_14
      r.edge_sel <= {`LAIS_NCH{`LAIS_EDGE_RST}};
    end else begin
      r <= n;
    end
  end

  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;
  assign irq_out = r.irq;

  a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    (|pend) |=> irq_out) else $error("pending flag not reported");
  a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
    !(|pend) |=> !irq_out) else $error("interrupt without pending flag");
  a_mask_reset: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
    $rose(presetn) |-> r.mask0[0] == `LAIS_MASK_RST) else $error("mask not reset");
  a_flag_reset: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    $rose(presetn) |-> flags0_w[0] == `LAIS_FLAG_RST) else $error("flag not reset");
  a_chan_read: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
    setup && !pwrite && off == `LAIS_IDX_FLAGS0 |=> prdata[7:0] == $past(flags0_w[ch_sel]))
    else $error("wrong channel flags read");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready) else $error("ready not one cycle");
  a_apb_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !hit |=> pslverr && pready) else $error("unmapped access not flagged");
  // Watches the channel that carries the pattern clear sequence
  a_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    wr_take && off == `LAIS_IDX_FLAGS1 && ch_sel == 4'h5 && pwdata[5] && !st1_w[5][5]
    && !$past(st1_w[5][5]) |=> !flags1_w[5][5]) else $error("write one did not clear");

  c_irq_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq_out));
  c_irq_clear: cover property (@(posedge pclk) disable iff (!presetn) irq_out ##1 !irq_out);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  c_any_edge: cover property (@(posedge pclk) disable iff (!presetn)
    r.edge_sel[5][`LAIS_ES_OC] && $fell(st0_w[5][4]));
endmodule

// ===== sim/tb_lais_irq_status.sv
// Self-checking bench for the line alarm interrupt status block
`timescale 1ns/1ps
`include "lais_defs.svh"
module tb_lais_irq_status;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_out;
  logic [15:0] amp;
  logic [15:0] txs;
  logic [15:0] rxs;
  logic [15:0] lv [10];
  int          mismatches;
  int          checks_done;
  logic [31:0] rdv;
  logic        err;
  // Level sources in port order: register, flag bit, edge-select bit
  localparam int REG_SEL [10] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 1};
  localparam int FLAG_BIT[10] = '{4, 3, 2, 1, 0, 7, 6, 5, 1, 0};
  localparam int EDGE_BIT[10] = '{4, 3, 2, 1, 1, 6, 6, 5, 0, 0};

  lais_irq_status i_lais_irq_status (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .irq_out                  (irq_out),
    .amplitude_overflow_evt   (amp),
    .tx_jitter_fifo_slip_evt  (txs),
    .rx_jitter_fifo_slip_evt  (rxs),
    .overcurrent_state        (lv[0]),
    .clock_missing_state      (lv[1]),
    .tx_signal_loss_state     (lv[2]),
    .system_signal_loss_state (lv[3]),
    .line_signal_loss_state   (lv[4]),
    .system_alarm_ind_state   (lv[5]),
    .line_alarm_ind_state     (lv[6]),
    .pattern_sync_state       (lv[7]),
    .loop_up_code_state       (lv[8]),
    .loop_down_code_state     (lv[9])
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  function automatic logic [11:0] adr(input logic [3:0] ch, input logic [5:0] idx);
    return {ch, idx, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the trailing idle edge keeps psel from being driven twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
    end
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rdv, {24'h000000, exp});
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #100us;
    mismatches++;
    test_done;
  end

  initial begin
    int          s;
    int          m;
    logic [5:0]  fi;
    logic [5:0]  si;
    logic [7:0]  bit_v;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    amp = 16'h0000;
    txs = 16'h0000;
    rxs = 16'h0000;
    for (s = 0; s < 10; s++) begin
      lv[s] = 16'h0000;
    end
    mismatches = 0;
    checks_done = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values of flags, masks and edge select
    rdc(adr(4'h0, `LAIS_IDX_FLAGS0), 8'h00);
    rdc(adr(4'hF, `LAIS_IDX_FLAGS1), 8'h00);
    rdc(adr(4'h3, `LAIS_IDX_MASK0), 8'hFF);
    rdc(adr(4'h3, `LAIS_IDX_MASK1), 8'hE3);
    rdc(adr(4'h3, `LAIS_IDX_EDGE), 8'h00);
    chk({31'h0, irq_out}, 32'h0);
    // Unmapped index answers with an error and zero data
    apb(1'b0, adr(4'h0, 6'h00), 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rdv, 32'h0);
    // Pulse events on channel 3, all masked at first
    amp[3] <= 1'b1;
    txs[3] <= 1'b1;
    rxs[3] <= 1'b1;
    @(posedge pclk);
    amp <= 16'h0000;
    txs <= 16'h0000;
    rxs <= 16'h0000;
    repeat (3) @(posedge pclk);
    rdc(adr(4'h3, `LAIS_IDX_FLAGS0), 8'hE0);
    rdc(adr(4'h6, `LAIS_IDX_FLAGS0), 8'h00);
    chk({31'h0, irq_out}, 32'h0);
    wr(adr(4'h3, `LAIS_IDX_MASK0), 8'h7F);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq_out}, 32'h1);
    wr(adr(4'h3, `LAIS_IDX_FLAGS0), 8'h80);
    rdc(adr(4'h3, `LAIS_IDX_FLAGS0), 8'h60);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq_out}, 32'h0);
    wr(adr(4'h3, `LAIS_IDX_MASK0), 8'h00);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq_out}, 32'h1);
    wr(adr(4'h3, `LAIS_IDX_FLAGS0), 8'h60);
    rdc(adr(4'h3, `LAIS_IDX_FLAGS0), 8'h00);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq_out}, 32'h0);
    // Every level source on channel 5, rising-only then any-edge mode
    for (s = 0; s < 10; s++) begin
      for (m = 0; m < 2; m++) begin
        fi = (REG_SEL[s] == 1) ? `LAIS_IDX_FLAGS1 : `LAIS_IDX_FLAGS0;
        si = (REG_SEL[s] == 1) ? `LAIS_IDX_STATE1 : `LAIS_IDX_STATE0;
        bit_v = 8'h01 << FLAG_BIT[s];
        wr(adr(4'h5, `LAIS_IDX_EDGE), (m == 1) ? (8'h01 << EDGE_BIT[s]) : 8'h00);
        lv[s][5] <= 1'b1;
        repeat (6) @(posedge pclk);
        rdc(adr(4'h5, fi), bit_v);
        chk({31'h0, err}, 32'h0);
        rdc(adr(4'h5, si), bit_v);
        wr(adr(4'h5, fi), bit_v);
        rdc(adr(4'h5, fi), 8'h00);
        lv[s][5] <= 1'b0;
        repeat (6) @(posedge pclk);
        rdc(adr(4'h5, fi), (m == 1) ? bit_v : 8'h00);
        rdc(adr(4'h5, si), 8'h00);
        wr(adr(4'h5, fi), bit_v);
      end
    end
    rdc(adr(4'h4, `LAIS_IDX_FLAGS1), 8'h00);
    // Second flag register reaches the interrupt once its mask bit is low
    wr(adr(4'h5, `LAIS_IDX_MASK1), 8'hDF);
    rdc(adr(4'h5, `LAIS_IDX_MASK1), 8'hC3);
    lv[7][5] <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({31'h0, irq_out}, 32'h1);
    wr(adr(4'h5, `LAIS_IDX_FLAGS1), 8'h20);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq_out}, 32'h0);
    test_done;
  end
endmodule
